/* File: tb/sar_comp_model.sv */
`timescale 1ns/100ps
// ideal comparator standing in for the analog front end
module sar_comp_model (
    // trial code from the converter
    input  wire logic [11:0] dac_code,
    // analog level expressed as a code
    input  wire logic [11:0] vin,
    // decision: high keeps the trial bit
    output logic             comp_high
);
    // settled at once, so a full-length finished word equals vin; no noise is modelled
    always_comb begin
        comp_high = (dac_code <= vin);
    end
endmodule : sar_comp_model

/* File: tb/test_adc_bus_control_logic.sv */
`timescale 1ns/100ps
module test_adc_bus_control_logic;
    logic        clk_sys;   // system clock
    logic        rst;       // sync reset
    logic        ce;        // chip enable pin
    logic        cs_n;      // chip select pin
    logic        rc;        // read high, convert low
    logic        ww;        // word width select
    logic        bs;        // byte / short cycle select
    logic [11:0] vin;       // analog level as a code
    logic        comp_high; // comparator decision
    logic [11:0] dac_code;  // trial code
    logic [11:0] data_out;  // data line values
    logic [11:0] data_oe;   // data line enables
    logic        busy;      // status pin
    int          n_errors;  // mismatches
    int          cmp_count; // comparisons
    int          busy_cnt;  // cycles busy was seen high
    int          d_ref;     // start delay of the plain case
    int          d;         // scratch delay
    int          len12;     // busy length, long cycle

    adc_bus_control_logic dut (
        .clk_sys(clk_sys), .rst(rst), .chip_enable(ce), .chip_select_n(cs_n),
        .read_convert(rc), .word_width_select(ww), .byte_short_cycle_select(bs),
        .comp_high(comp_high), .dac_code(dac_code), .conversion_busy_flag(busy),
        .data_out(data_out), .data_oe(data_oe));
    sar_comp_model far (.dac_code(dac_code), .vin(vin), .comp_high(comp_high));

    // free running clock, 4 ns
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // busy length counter, zeroed before each start by run or by the busy-restart step
    always @(posedge clk_sys) begin
        if (busy === 1'b1) begin
            busy_cnt <= busy_cnt + 1;
        end
    end

    task automatic end_sim();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    // pins in order ce, cs_n, rc, ww, bs, changed at the falling edge
    task automatic pins(input logic [4:0] p);
        @(negedge clk_sys);
        {ce, cs_n, rc, ww, bs} = p;
    endtask : pins

    // pins pass three flops, so give them time to land
    task automatic settle();
        repeat (6) @(posedge clk_sys);
        #1;
    endtask : settle

    // bounded wait for a busy level, n returns the cycles taken
    task automatic wait_busy(input logic lvl, output int n);
        n = 0;
        while (busy !== lvl && n < 200) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 200) begin
            n_errors++;
            $display("Error at %0t: busy wait ran out", $time);
        end
    endtask : wait_busy

    // quiet state pre, then go makes the start condition complete
    task automatic run(input logic [4:0] pre, input logic [4:0] go,
                       input logic [11:0] v, output int dly);
        int n;
        vin = v;
        pins(pre);
        repeat (4) @(posedge clk_sys);
        pins(go);
        busy_cnt = 0;
        wait_busy(1'b1, dly);
        pins(go | 5'b00100);
        settle();
        check(data_oe, 12'h000);
        wait_busy(1'b0, n);
    endtask : run

    // word read, high byte, then low nibble with overlap watched
    task automatic read_all(input logic [11:0] exp);
        pins(5'b10110);
        settle();
        check(data_oe, 12'hFFF);
        check(data_out, exp);
        pins(5'b10100);
        settle();
        check(data_oe, 12'hFF0);
        check(data_out & data_oe, {exp[11:4], 4'h0});
        pins(5'b10101);
        repeat (8) begin
            @(posedge clk_sys);
            #1;
            check({11'h0, |data_oe[11:8] & |data_oe[3:0]}, 12'h000);
        end
        check(data_oe, 12'h0FF);
        check(data_out & data_oe, {8'h00, exp[3:0]});
        pins(5'b10110);
    endtask : read_all

    // watchdog: the whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        n_errors = 0;
        cmp_count = 0;
        busy_cnt = 0;
        {ce, cs_n, rc, ww, bs} = 5'b10110;
        vin = 12'h000;
        rst = 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        // stand-alone: only the read/convert line moves
        run(5'b10110, 5'b10010, 12'hA5C, d_ref);
        len12 = busy_cnt;
        check(12'(d_ref) - 12'h001 < 12'h008, 12'h001);
        read_all(12'hA5C);
        // short cycle: four decisions fewer, tail reads one then zeros
        run(5'b10111, 5'b10011, 12'h3F1, d);
        check(12'(len12 - busy_cnt), 12'(4 * adc_ctl_pkg::STEP_CYCLES));
        read_all(12'h3F8);
        // chip enable last, select last, all three at once
        run(5'b00010, 5'b10010, 12'hFFF, d);
        check(12'(d), 12'(d_ref));
        read_all(12'hFFF);
        run(5'b11010, 5'b10010, 12'h000, d);
        check(12'(d), 12'(d_ref));
        read_all(12'h000);
        run(5'b01110, 5'b10010, 12'h801, d);
        check(12'(d), 12'(d_ref));
        read_all(12'h801);
        // second start while busy must not restart, but re-latches a short length
        vin = 12'h5A5;
        pins(5'b10010);
        busy_cnt = 0;
        wait_busy(1'b1, d);
        pins(5'b11010);
        repeat (3) @(negedge clk_sys);
        pins(5'b10011);
        pins(5'b10111);
        wait_busy(1'b0, d);
        check(12'(busy_cnt), 12'(len12 - 4 * adc_ctl_pkg::STEP_CYCLES));
        read_all(12'h5A8);
        // disabled or deselected: no start and no drive
        pins(5'b00110);
        settle();
        check(data_oe, 12'h000);
        pins(5'b00010);
        settle();
        check({11'h0, busy}, 12'h000);
        pins(5'b11110);
        settle();
        check(data_oe, 12'h000);
        pins(5'b11010);
        settle();
        check({11'h0, busy}, 12'h000);
        pins(5'b11110);
        pins(5'b10110);
        settle();
        check(data_out, 12'h5A8);
        end_sim();
    end
endmodule : test_adc_bus_control_logic

/* File: verilog/adc_bus_control_logic.sv */
`timescale 1ns/100ps
// Contract
// - results readable as word or two bytes
// - chip disabled or deselected means no action
// - last of three start inputs starts conversion
// - equal start delay, simultaneous changes allowed
// - byte select latched at start sets length
// - short result reads low zeros, bit three one
// - only byte select is latched
// - busy flag high exactly during conversion; flag stays high until one cycle after the result is latched
// - data outputs off while busy
// - start while busy does not restart
// - start while busy re-latches length select
// - outputs off unless all four read conditions
// - word mode drives all twelve bits
// - byte mode drives high byte or nibble
// - low byte forces bits four to seven zero
// - break before make between the bytes
module adc_bus_control_logic (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // control pins, asynchronous to clk_sys
    input  wire logic        chip_enable,
    input  wire logic        chip_select_n,
    input  wire logic        read_convert,
    input  wire logic        word_width_select,
    input  wire logic        byte_short_cycle_select,
    // comparator from the analog side, asynchronous
    input  wire logic        comp_high,
    // trial code toward the dac
    output logic      [11:0] dac_code,
    // status pin
    output logic             conversion_busy_flag,
    // data pins, three-state as value and enable per line
    output logic      [11:0] data_out,
    output logic      [11:0] data_oe
);
    // pin synchronisers: first stage feeds only the second
    logic [5:0] pin_meta_reg;  // first stage
    logic [5:0] pin_sync_reg;  // second stage
    logic [5:0] pin_prev_reg;  // previous synchronised sample

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_meta_reg <= 6'h00;
            pin_sync_reg <= 6'h00;
            pin_prev_reg <= 6'h00;
        end else begin
            pin_meta_reg <= {comp_high, byte_short_cycle_select, word_width_select,
                             read_convert, chip_select_n, chip_enable};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    // live synchronised levels, all except length select act as they are
    logic ce_s;   // chip enable
    logic csn_s;  // chip select, low active
    logic rc_s;   // read high, convert low
    logic ww_s;   // word width select
    logic bs_s;   // byte / short-cycle select
    logic cmp_s;  // comparator
    assign ce_s  = pin_sync_reg[0];
    assign csn_s = pin_sync_reg[1];
    assign rc_s  = pin_sync_reg[2];
    assign ww_s  = pin_sync_reg[3];
    assign bs_s  = pin_sync_reg[4];
    assign cmp_s = pin_sync_reg[5];

    // start condition as one level of three inputs
    function automatic logic start_level(input logic [5:0] p);
        start_level = p[0] && !p[1] && !p[2];
    endfunction : start_level

    // start fires on the rising edge of the combined level, so whichever
    // input arrives last, or all at once, gives the same delay through the two sync flops
    logic start_now;
    assign start_now = start_level(pin_sync_reg) && !start_level(pin_prev_reg);

    // device is inert while disabled or deselected
    logic selected;
    assign selected = ce_s && !csn_s;

    sar_if link ();

    // length select latched at each start, even a start while busy
    logic short_reg;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            short_reg <= 1'b0;
        end else if (start_now && selected) begin
            short_reg <= bs_s;
        end
    end
    assign link.short_mode = short_reg;
    // the latch lands at the same edge as the start, before the sequencer first reads the length
    assign link.start = start_now && selected && !link.busy;

    logic [11:0] trial_w;  // working code from the sequencer

    sar_core u_sar (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .comp_high  (cmp_s),
        .trial_code (trial_w),
        .ctl        (link)
    );

    // trial code mirrors the working register while busy and is zero otherwise, registered for the pin
    logic [11:0] dac_next;
    assign dac_next = link.busy ? trial_w : 12'h000;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dac_code <= 12'h000;
        end else begin
            dac_code <= dac_next;
        end
    end

    // busy pin: rises with the start, falls one cycle after the result is latched
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            conversion_busy_flag <= 1'b0;
        end else begin
            conversion_busy_flag <= link.start || link.busy;
        end
    end

    // read enable needs all four conditions, evaluated live
    logic read_ok;
    assign read_ok = rc_s && selected && !link.busy && !link.start;

    // which lanes want to drive this cycle
    logic [11:0] want_oe;   // requested enables
    logic [11:0] want_data; // requested values
    always_comb begin
        want_oe   = 12'h000;
        want_data = 12'h000;
        if (read_ok) begin
            if (ww_s) begin
                // full word, length select ignored
                want_oe   = 12'hFFF;
                want_data = link.result;
            end else if (!bs_s) begin
                // high byte on the upper eight lines
                want_oe   = 12'hFF0;
                want_data = {link.result[11:4], 4'h0};
            end else begin
                // nibble on lines three..zero, lines seven..four forced zero,
                // top four lines off so they can share wires with the low nibble
                want_oe   = 12'h0FF;
                want_data = {8'h00, link.result[3:0]};
            end
        end
    end

    // byte lanes: upper eight lines and lower eight lines; a switch between
    // byte halves passes one cycle with both halves off (break before make)
    logic hi_reg;  // high byte was enabled last cycle
    logic lo_reg;  // low byte was enabled last cycle
    logic want_hi;
    logic want_lo;
    assign want_hi = read_ok && !ww_s && !bs_s;
    assign want_lo = read_ok && !ww_s && bs_s;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hi_reg   <= 1'b0;
            lo_reg   <= 1'b0;
            data_oe  <= 12'h000;
            data_out <= 12'h000;
        end else begin
            if ((want_hi && lo_reg) || (want_lo && hi_reg)) begin
                // drop everything one cycle before the other byte
                hi_reg  <= 1'b0;
                lo_reg  <= 1'b0;
                data_oe <= 12'h000;
            end else begin
                hi_reg  <= want_hi;
                lo_reg  <= want_lo;
                data_oe <= want_oe;
            end
            data_out <= want_data;
        end
    end

    // assertions
    a_busy_blanks_out: assert property (@(posedge clk_sys) disable iff (rst)
        conversion_busy_flag |-> data_oe == 12'h000)
        else $error("data driven while busy");
    a_bytes_never_both: assert property (@(posedge clk_sys) disable iff (rst)
        !(data_oe[11:8] != 4'h0 && data_oe[3:0] != 4'h0 && data_oe != 12'hFFF))
        else $error("both byte halves enabled");
    a_deselect_no_start: assert property (@(posedge clk_sys) disable iff (rst)
        !selected |-> !link.start)
        else $error("start while deselected");
    a_start_raises_busy: assert property (@(posedge clk_sys) disable iff (rst)
        link.start |=> conversion_busy_flag [*2])
        else $error("busy missing after start");
    a_low_byte_zero: assert property (@(posedge clk_sys) disable iff (rst)
        (want_lo && !hi_reg) |=> data_out[11:4] == 8'h00 && data_oe[11:8] == 4'h0)
        else $error("low byte upper lines wrong");
    a_word_mode_all: assert property (@(posedge clk_sys) disable iff (rst)
        (read_ok && ww_s) |=> data_oe == 12'hFFF && data_out == $past(link.result))
        else $error("word read not full");
    a_length_latched: assert property (@(posedge clk_sys) disable iff (rst)
        (start_now && selected) |=> short_reg == $past(bs_s))
        else $error("length select not latched");
    a_short_len: assert property (@(posedge clk_sys) disable iff (rst)
        link.start |-> ##[1:200] link.done)
        else $error("conversion too long");

    c_full_conv: cover property (@(posedge clk_sys) link.start && !bs_s ##[1:200] link.done);
    c_short_conv: cover property (@(posedge clk_sys) link.start && bs_s ##[1:200] link.done);
    c_byte_switch: cover property (@(posedge clk_sys) hi_reg ##1 !hi_reg ##1 lo_reg);
    c_restart_busy: cover property (@(posedge clk_sys) start_now && selected && link.busy);
endmodule : adc_bus_control_logic

/* File: verilog/adc_ctl_pkg.sv */
package adc_ctl_pkg;
    // result width and short-cycle length
    localparam int RESULT_BITS   = 12;
    localparam int SHORT_BITS    = 8;
    localparam int NIBBLE_BITS   = 4;
    // clock period and nominal bit decision time
    localparam int CLK_PERIOD_PS = 4000;
    localparam int BIT_TIME_NS   = 1;
    localparam int BIT_CYCLES    = (BIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // comparator answer lags the trial code by the dac register and two sync flops,
    // so a decision taken sooner would judge the previous trial code
    localparam int COMP_LOOP_CYCLES = 3;
    localparam int STEP_CYCLES      = BIT_CYCLES + COMP_LOOP_CYCLES;
    // value after reset of the result register
    localparam logic [11:0] RESULT_RESET = 12'h000;
    // bit three set after a short conversion
    localparam logic [3:0]  SHORT_TAIL   = 4'h8;
    // converter sequencer states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DECIDE,
        ST_DONE
    } conv_state_t;
endpackage : adc_ctl_pkg

/* File: verilog/sar_core.sv */
`timescale 1ns/100ps
// successive approximation sequencer, one decision per step
module sar_core (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // comparator answer, already synchronised
    input  wire logic comp_high,
    // trial code toward the dac
    output logic [11:0] trial_code,
    // control side
    sar_if.sar        ctl
);
    adc_ctl_pkg::conv_state_t state_reg;
    logic [3:0]  bit_idx_reg;  // bit being decided
    logic [11:0] code_reg;     // working code
    logic [7:0]  wait_reg;     // settle counter

    assign trial_code = code_reg;

    // sequencer: a restart while busy is ignored, only length may move
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg   <= adc_ctl_pkg::ST_IDLE;
            bit_idx_reg <= 4'hB;
            code_reg    <= adc_ctl_pkg::RESULT_RESET;
            wait_reg    <= 8'h00;
            ctl.busy    <= 1'b0;
            ctl.done    <= 1'b0;
            ctl.result  <= adc_ctl_pkg::RESULT_RESET;
        end else begin
            ctl.done <= 1'b0;
            case (state_reg)
                adc_ctl_pkg::ST_IDLE: begin
                    if (ctl.start) begin
                        state_reg   <= adc_ctl_pkg::ST_DECIDE;
                        bit_idx_reg <= 4'hB;
                        code_reg    <= 12'h800;
                        wait_reg    <= 8'(adc_ctl_pkg::STEP_CYCLES - 1);
                        ctl.busy    <= 1'b1;
                    end
                end
                adc_ctl_pkg::ST_DECIDE: begin
                    if (wait_reg != 8'h00) begin
                        wait_reg <= wait_reg - 8'h01;
                    end else begin
                        // keep or drop the trial bit, then try the next one
                        if (!comp_high) begin
                            code_reg[bit_idx_reg] <= 1'b0;
                        end
                        wait_reg <= 8'(adc_ctl_pkg::STEP_CYCLES - 1);
                        // short length is read live, so a re-latch can cut it
                        if (bit_idx_reg == 4'h0 ||
                            (ctl.short_mode && bit_idx_reg == 4'h4)) begin
                            state_reg <= adc_ctl_pkg::ST_DONE;
                        end else begin
                            bit_idx_reg <= bit_idx_reg - 4'h1;
                            code_reg[bit_idx_reg - 4'h1] <= 1'b1;
                        end
                    end
                end
                adc_ctl_pkg::ST_DONE: begin
                    // short result: low three bits zero, bit three one
                    if (ctl.short_mode) begin
                        ctl.result <= {code_reg[11:4], adc_ctl_pkg::SHORT_TAIL};
                    end else begin
                        ctl.result <= code_reg;
                    end
                    ctl.busy  <= 1'b0;
                    ctl.done  <= 1'b1;
                    state_reg <= adc_ctl_pkg::ST_IDLE;
                end
                default: state_reg <= adc_ctl_pkg::ST_IDLE;
            endcase
        end
    end

    // busy and done never overlap the idle state wrongly
    a_done_clears_busy: assert property (@(posedge clk_sys) disable iff (rst)
        ctl.done |-> !ctl.busy && $past(ctl.busy))
        else $error("done without busy falling");
    a_restart_ignored: assert property (@(posedge clk_sys) disable iff (rst)
        (ctl.busy && state_reg == adc_ctl_pkg::ST_DECIDE)
        |=> $stable(bit_idx_reg) || bit_idx_reg == $past(bit_idx_reg) - 4'h1
        || state_reg == adc_ctl_pkg::ST_DONE)
        else $error("restart disturbed running conversion");
    a_short_tail: assert property (@(posedge clk_sys) disable iff (rst)
        (ctl.done && ctl.short_mode) |-> ctl.result[3:0] == 4'h8)
        else $error("short result tail wrong");
endmodule : sar_core

/* File: verilog/sar_if.sv */
`timescale 1ns/100ps
// path between the control logic and the approximation register
interface sar_if;
    logic        start;      // one-cycle start pulse
    logic        short_mode; // live latched length select
    logic        busy;       // conversion running
    logic        done;       // one-cycle end pulse
    logic [11:0] result;     // finished word
    modport ctl (output start, output short_mode, input busy, input done, input result);
    modport sar (input start, input short_mode, output busy, output done, output result);
endinterface : sar_if
